// ==== src/cba_agu.sv ====
// Purpose: Circular-buffer and bit-reversed effective-address generator
// Assumes: Execution stage presents one request per cycle; one cycle latency
// Notes:
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "cba_consts.svh"
`default_nettype none

module cba_agu
	import cba_pkg::*;
(
	input  wire logic        clock,     // 40 MHz core clock
	input  wire logic        reset_n,   // Synchronous reset, active low
	input  wire logic [2:0]  regAddr,   // Register index
	input  wire logic [15:0] regWrData, // Register write data
	input  wire logic        regWr,     // Write strobe
	input  wire logic        regRd,     // Read strobe
	output logic      [15:0] regRdData, // Read data, cycle after strobe
	input  wire cba_req_t    req,       // Address request from execution stage
	output cba_res_t         res        // Generated address and write-back
);
	cba_state_t st_r;
	cba_state_t st_nxt;

	logic [3:0]  xSel;
	logic [3:0]  ySel;
	logic [3:0]  bSel;
	logic        isMod;
	logic        isInc;
	logic        isDec;
	logic        xCircOn;
	logic        yCircOn;
	logic        brevOn;
	logic        circOn;
	logic [15:0] lo;
	logic [15:0] hi;
	logic [15:0] sum;
	logic [15:0] corr;
	logic [15:0] eff;
	logic [14:0] ptrRev;
	logic [14:0] modRev;
	logic [14:0] revSum;
	logic [14:0] idxNew;
	logic [15:0] brevPtr;

	assign xSel = st_r.modeCtl[`CBA_XSEL_LSB +: 4];
	assign ySel = st_r.modeCtl[`CBA_YSEL_LSB +: 4];
	assign bSel = st_r.modeCtl[`CBA_BSEL_LSB +: 4];
	assign isMod = (req.mode == CBA_POSTMOD) || (req.mode == CBA_PREMOD);
	assign isInc = !req.step[15] && (|req.step);
	assign isDec = req.step[15];
	assign sum = req.regVal + req.step;

	// Pointer match is a full 4-bit compare, so registers 0 to 14 qualify; select 15 turns it off
	assign xCircOn = !req.ySpace && (xSel != `CBA_SEL_OFF) && st_r.modeCtl[`CBA_XEN_BIT]
		&& (req.regSel == xSel);
	assign yCircOn = req.ySpace && (ySel != `CBA_SEL_OFF) && st_r.modeCtl[`CBA_YEN_BIT]
		&& (req.regSel == ySel);
	assign brevOn = !req.ySpace && req.write && !req.byteSize && isMod && isInc
		&& (bSel != `CBA_SEL_OFF) && st_r.brevCtl[`CBA_REVERSE_ENABLE_BIT]
		&& (req.regSel == bSel);
	assign circOn = (xCircOn && !brevOn) || yCircOn;

	assign lo = req.ySpace ? st_r.yStart : st_r.xStart;
	assign hi = req.ySpace ? st_r.yEnd : st_r.xEnd;

	// Strict compares, so a step that jumps well past a bound still wraps
	always_comb begin
		corr = sum;
		if (isInc && (sum > hi)) begin
			corr = lo + (sum - hi - 16'h0001);
		end else if (isDec && (sum < lo)) begin
			corr = hi - (lo - sum - 16'h0001);
		end
	end
	assign eff = circOn ? corr : sum;

	// Reverse-carry add: mirror word index and modifier, add, mirror back
	for (genvar i = 0; i < 15; i++) begin : g_rev
		assign ptrRev[i] = req.regVal[15-i];
		assign modRev[i] = st_r.brevCtl[14-i];
		assign idxNew[i] = revSum[14-i];
	end
	assign revSum = ptrRev + modRev;
	assign brevPtr = {idxNew, 1'b0};

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdData = 16'h0000;
		if (regWr) begin
			unique case (regAddr)
				`CBA_REG_MODE:   st_nxt.modeCtl = regWrData;
				`CBA_REG_BREV:   st_nxt.brevCtl = regWrData;
				`CBA_REG_XSTART: st_nxt.xStart = regWrData;
				`CBA_REG_XEND:   st_nxt.xEnd = regWrData;
				`CBA_REG_YSTART: st_nxt.yStart = regWrData;
				`CBA_REG_YEND:   st_nxt.yEnd = regWrData;
				default: ;
			endcase
		end
		if (regRd) begin
			unique case (regAddr)
				`CBA_REG_MODE:   st_nxt.rdData = st_r.modeCtl;
				`CBA_REG_BREV:   st_nxt.rdData = st_r.brevCtl;
				`CBA_REG_XSTART: st_nxt.rdData = st_r.xStart;
				`CBA_REG_XEND:   st_nxt.rdData = st_r.xEnd;
				`CBA_REG_YSTART: st_nxt.rdData = st_r.yStart;
				`CBA_REG_YEND:   st_nxt.rdData = st_r.yEnd;
				default:         st_nxt.rdData = 16'h0000;
			endcase
		end
		st_nxt.res = '0;
		st_nxt.res.valid = req.valid;
		st_nxt.res.write = req.write;
		st_nxt.res.ySpace = req.ySpace;
		st_nxt.res.wbSel = req.regSel;
		if (req.valid) begin
			st_nxt.res.circ = circOn && (req.mode != CBA_INDIRECT);
			st_nxt.res.reversed = brevOn;
			unique case (req.mode)
				CBA_INDIRECT: begin
					st_nxt.res.addr = req.regVal;
				end
				CBA_POSTMOD: begin
					st_nxt.res.addr = brevOn ? {req.regVal[15:1], 1'b0} : req.regVal;
					st_nxt.res.wbValid = 1'b1;
					st_nxt.res.wbData = brevOn ? brevPtr : eff;
				end
				CBA_PREMOD: begin
					st_nxt.res.addr = brevOn ? brevPtr : eff;
					st_nxt.res.wbValid = 1'b1;
					st_nxt.res.wbData = brevOn ? brevPtr : eff;
				end
				CBA_REGOFF, CBA_LITOFF: begin
					// Offset forms correct the address but leave the pointer alone
					st_nxt.res.addr = eff;
				end
				default: st_nxt.res.addr = req.regVal;
			endcase
			// Y space is word data only
			if (req.ySpace) begin
				st_nxt.res.addr[0] = 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			st_r <= '0;
			st_r.modeCtl <= `CBA_MODE_RST;
			st_r.brevCtl <= `CBA_BREV_RST;
			st_r.xStart <= `CBA_BUF_RST;
			st_r.xEnd <= `CBA_BUF_RST;
			st_r.yStart <= `CBA_BUF_RST;
			st_r.yEnd <= `CBA_BUF_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdData = st_r.rdData;
	assign res = st_r.res;

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_x_premod_off;
		req.valid && !req.ySpace && (req.mode == CBA_PREMOD) && (xSel == `CBA_SEL_OFF)
			&& !brevOn && !yCircOn;
	endsequence

	sequence s_rev_write;
		req.valid && brevOn;
	endsequence

	sequence s_rev_read;
		req.valid && !req.ySpace && !req.write && (req.mode == CBA_POSTMOD) && isInc
			&& st_r.brevCtl[`CBA_REVERSE_ENABLE_BIT] && (bSel != `CBA_SEL_OFF) && (req.regSel == bSel);
	endsequence

	a_x_sel_off: assert property (
		s_x_premod_off |=> res.valid && !res.circ && (res.wbData == $past(sum)))
		else $error("X circular correction applied with select 15");

	a_y_en_off: assert property (
		req.valid && req.ySpace && !st_r.modeCtl[`CBA_YEN_BIT] |=> !res.circ)
		else $error("Y circular correction applied while disabled");

	a_offset_nowb: assert property (
		req.valid && ((req.mode == CBA_REGOFF) || (req.mode == CBA_LITOFF))
		|=> res.valid && !res.wbValid)
		else $error("Offset mode wrote the pointer back");

	a_wrap_inc: assert property (
		req.valid && xCircOn && !brevOn && (req.mode == CBA_PREMOD) && isInc
		&& (sum > st_r.xEnd) && (req.regVal >= st_r.xStart) && (req.regVal <= st_r.xEnd)
		&& (req.step <= (st_r.xEnd - st_r.xStart))
		|=> res.circ && (res.addr >= $past(st_r.xStart)) && (res.addr <= $past(st_r.xEnd)))
		else $error("Incrementing pointer not wrapped into the buffer");

	a_rev_lsb: assert property (
		s_rev_write |=> res.reversed && !res.addr[0] && !res.wbData[0])
		else $error("Reversed address has LSB set");

	a_rev_read_none: assert property (
		s_rev_read |=> !res.reversed && (res.addr == $past(req.regVal)))
		else $error("Bit reversal applied to a read");

	a_rev_byte_none: assert property (
		req.valid && req.write && req.byteSize |=> !res.reversed)
		else $error("Bit reversal applied to a byte write");

	a_rev_prio: assert property (
		s_rev_write ##0 xCircOn |=> !res.circ ##1 1'b1)
		else $error("X write circular not overridden by reversal");

	// A one-word modifier toggles only the lowest index bit; its carry falls off the top
	a_rev_step: assert property (
		s_rev_write ##0 (st_r.brevCtl[14:0] == 15'h0001)
		|=> ((res.wbData ^ $past(req.regVal)) & 16'hfffe) == 16'h0002)
		else $error("Reversed step of one word did not toggle the lowest index bit");

	a_rev_post_ea: assert property (
		s_rev_write ##0 (req.mode == CBA_POSTMOD)
		|=> !res.addr[0] && ((res.addr | 16'h0001) == ($past(req.regVal) | 16'h0001)))
		else $error("Reversed post-increment address is not the old pointer");

	a_x_en_off: assert property (
		req.valid && !req.ySpace && !st_r.modeCtl[`CBA_XEN_BIT] |=> !res.circ)
		else $error("X circular correction applied while disabled");

	a_y_sel_off: assert property (
		req.valid && req.ySpace && (ySel == `CBA_SEL_OFF) |=> !res.circ)
		else $error("Y circular correction applied with select 15");

	a_any_reg: assert property (
		req.valid && !req.ySpace && (req.mode == CBA_PREMOD) && !brevOn
		&& (xSel != `CBA_SEL_OFF) && st_r.modeCtl[`CBA_XEN_BIT] && (req.regSel == xSel)
		|=> res.circ)
		else $error("Selected pointer register missed circular correction");

	a_wrap_dec: assert property (
		req.valid && xCircOn && !brevOn && (req.mode == CBA_POSTMOD) && isDec
		&& (sum < st_r.xStart) && (req.regVal >= st_r.xStart) && (req.regVal <= st_r.xEnd)
		&& ((16'h0000 - req.step) <= (st_r.xEnd - st_r.xStart))
		|=> res.circ && (res.wbData >= $past(st_r.xStart)) && (res.wbData <= $past(st_r.xEnd)))
		else $error("Decrementing pointer not wrapped into the buffer");

	a_postmod_ea: assert property (
		req.valid && !req.ySpace && (req.mode == CBA_POSTMOD) && !brevOn
		|=> res.wbValid && (res.addr == $past(req.regVal)))
		else $error("Post-modify address is not the old pointer");

	a_premod_ea: assert property (
		req.valid && !req.ySpace && (req.mode == CBA_PREMOD)
		|=> res.wbValid && (res.addr == res.wbData))
		else $error("Pre-modify address differs from the written-back pointer");

	a_indirect_plain: assert property (
		req.valid && (req.mode == CBA_INDIRECT)
		|=> res.valid && !res.wbValid && !res.circ && !res.reversed)
		else $error("Plain indirect access modified the pointer");

	a_rev_dec_none: assert property (
		req.valid && req.write && isDec |=> !res.reversed)
		else $error("Bit reversal applied to a decrementing access");

	a_res_idle: assert property (
		!req.valid |=> !res.valid && !res.wbValid)
		else $error("Result or write-back without a request");

	// Y space carries word data only, so its addresses stay even
	a_y_word: assert property (
		req.valid && req.ySpace |=> !res.addr[0])
		else $error("Y space address has LSB set");

	// Stale read data would look like a fresh answer to a polling master
	a_rd_idle: assert property (
		!regRd |=> regRdData == 16'h0000)
		else $error("Read data present without a read strobe");

	a_rd_mode: assert property (
		regRd && (regAddr == `CBA_REG_MODE) ##1 !$past(regWr)
		|-> regRdData == st_r.modeCtl)
		else $error("Mode control read back wrong");

endmodule

`default_nettype wire

// ==== src/cba_consts.svh ====
// Purpose: Offsets, field positions and reset values of the circular/bit-reverse AGU
// Assumes: Register indices are word indices on the plain register port
// Notes:   Definitions only
`ifndef CBA_CONSTS_SVH
`define CBA_CONSTS_SVH
`define CBA_REG_MODE   3'h0
`define CBA_REG_BREV   3'h1
`define CBA_REG_XSTART 3'h2
`define CBA_REG_XEND   3'h3
`define CBA_REG_YSTART 3'h4
`define CBA_REG_YEND   3'h5
`define CBA_XSEL_LSB   0
`define CBA_YSEL_LSB   4
`define CBA_BSEL_LSB   8
`define CBA_XEN_BIT    15
`define CBA_YEN_BIT    14
`define CBA_REVERSE_ENABLE_BIT   15
`define CBA_SEL_OFF    4'hf
`define CBA_MODE_RST   16'h0fff
`define CBA_BREV_RST   16'h0000
`define CBA_BUF_RST    16'h0000
`endif

// ==== src/cba_pkg.sv ====
// Purpose: Types of the circular/bit-reverse AGU
// Assumes: 16-bit data addresses, sixteen working registers
// Notes:   Addressing modes are one-hot
package cba_pkg;
	typedef enum logic [4:0] {
		CBA_INDIRECT = 5'b00001,
		CBA_POSTMOD  = 5'b00010,
		CBA_PREMOD   = 5'b00100,
		CBA_REGOFF   = 5'b01000,
		CBA_LITOFF   = 5'b10000
	} cba_mode_t;

	typedef struct packed {
		logic        valid;
		logic        ySpace;
		logic        write;
		logic        byteSize;
		cba_mode_t   mode;
		logic [3:0]  regSel;
		logic [15:0] regVal;
		logic [15:0] step;
	} cba_req_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        ySpace;
		logic        circ;
		logic        reversed;
		logic [15:0] addr;
		logic        wbValid;
		logic [3:0]  wbSel;
		logic [15:0] wbData;
	} cba_res_t;

	typedef struct packed {
		logic [15:0] modeCtl;
		logic [15:0] brevCtl;
		logic [15:0] xStart;
		logic [15:0] xEnd;
		logic [15:0] yStart;
		logic [15:0] yEnd;
		logic [15:0] rdData;
		cba_res_t    res;
	} cba_state_t;
endpackage

// ==== tb/cba_core_model.sv ====
// Purpose: Working-register file of the execution stage, fed by pointer write-back
// Assumes: One write-back per cycle, taken on the edge after the result stands
// Notes:   No reset; a pointer is only read after it was written
`timescale 1ns/1ps
`default_nettype none

module cba_core_model
	import cba_pkg::*;
(
	input  wire logic     clock, // Core clock
	input  wire cba_res_t res,   // Result of the address generator
	output logic [15:0]   ptr [16] // Working registers
);
	always_ff @(posedge clock) begin
		if (res.wbValid) begin
			ptr[res.wbSel] <= res.wbData;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_circular_and_bit_reverse_agu.sv ====
// Purpose: Self-checking bench of the circular and bit-reversed address generator
// Assumes: Fixed one-cycle latency on both ports
// Notes:   Circular bounds are set so that a wrong priority shows in the address
`timescale 1ns/1ps
`default_nettype none

module tb_circular_and_bit_reverse_agu;
	import cba_pkg::*;
	logic        clock = 0;
	logic        reset_n = 0;
	logic [2:0]  regAddr = 0;
	logic [15:0] regWrData = 0;
	logic        regWr = 0;
	logic        regRd = 0;
	logic [15:0] regRdData;
	cba_req_t    req = '0;
	cba_res_t    res;
	cba_res_t    r;
	logic [15:0] ptr [16];
	int          mismatches = 0;
	int          checksDone = 0;

	cba_agu uut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .req(req), .res(res));
	cba_core_model core (.clock(clock), .res(res), .ptr(ptr));

	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic stop_test;
		if (mismatches == 0 && checksDone > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [34:0] seen, input logic [34:0] exp);
		checksDone++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clock);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge clock);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRd <= 1'b0;
		#1 check({19'h0, regRdData}, {19'h0, e});
	endtask

	task automatic agu(input logic ys, w, b, input cba_mode_t m, input logic [3:0] s,
		input logic [15:0] v, st);
		@(posedge clock);
		req <= '{1'b1, ys, w, b, m, s, v, st};
		@(posedge clock);
		req.valid <= 1'b0;
		#1 r = res;
		check({28'h0, r.valid, r.write, r.ySpace, r.wbSel}, {28'h0, 1'b1, w, ys, s});
	endtask

	task automatic ex(input logic [15:0] a, input logic wv, input logic [15:0] wd,
		input logic c, rv);
		check({r.addr, r.wbValid, r.wbData, r.circ, r.reversed}, {a, wv, wd, c, rv});
	endtask

	function automatic logic [3:0] rev4(input logic [3:0] x);
		return {x[0], x[1], x[2], x[3]};
	endfunction

	task automatic t_regs;
		rd(3'h0, 16'h0fff);
		rd(3'h1, 16'h0000);
		rd(3'h3, 16'h0000);
		wr(3'h6, 16'h1234);
		rd(3'h6, 16'h0000);
	endtask

	task automatic t_xcirc;
		wr(3'h2, 16'h0800);
		wr(3'h3, 16'h081f);
		wr(3'h0, 16'h8ff3);
		rd(3'h0, 16'h8ff3);
		agu(0, 0, 0, CBA_PREMOD, 4'h3, 16'h081e, 16'h0004);
		ex(16'h0802, 1, 16'h0802, 1, 0);
		agu(0, 0, 0, CBA_REGOFF, 4'h3, 16'h081e, 16'h0004);
		check({19'h0, ptr[3]}, 35'h0802);
		ex(16'h0802, 0, 16'h0000, 1, 0);
		agu(0, 0, 0, CBA_INDIRECT, 4'h3, 16'h0810, 16'h0000);
		ex(16'h0810, 0, 16'h0000, 0, 0);
		agu(0, 0, 0, CBA_LITOFF, 4'h3, 16'h0810, 16'h0020);
		ex(16'h0810, 0, 16'h0000, 1, 0);
		agu(0, 0, 0, CBA_POSTMOD, 4'h3, 16'h0800, 16'hfffe);
		ex(16'h0800, 1, 16'h081e, 1, 0);
		agu(0, 0, 0, CBA_PREMOD, 4'h3, 16'h081c, 16'h0003);
		ex(16'h081f, 1, 16'h081f, 1, 0);
		agu(0, 0, 0, CBA_PREMOD, 4'h4, 16'h081e, 16'h0004);
		ex(16'h0822, 1, 16'h0822, 0, 0);
		wr(3'h0, 16'h0ff3);
		agu(0, 0, 0, CBA_PREMOD, 4'h3, 16'h081e, 16'h0004);
		ex(16'h0822, 1, 16'h0822, 0, 0);
		wr(3'h0, 16'h8fff);
		agu(0, 0, 0, CBA_PREMOD, 4'hf, 16'h081e, 16'h0004);
		ex(16'h0822, 1, 16'h0822, 0, 0);
	endtask

	task automatic t_ycirc;
		wr(3'h4, 16'h0900);
		wr(3'h5, 16'h091f);
		wr(3'h0, 16'h4f5f);
		agu(1, 0, 0, CBA_PREMOD, 4'h5, 16'h091e, 16'h0002);
		ex(16'h0900, 1, 16'h0900, 1, 0);
		agu(0, 0, 0, CBA_PREMOD, 4'h5, 16'h091e, 16'h0002);
		ex(16'h0920, 1, 16'h0920, 0, 0);
		wr(3'h0, 16'h0f5f);
		agu(1, 0, 0, CBA_PREMOD, 4'h5, 16'h091e, 16'h0002);
		ex(16'h0920, 1, 16'h0920, 0, 0);
	endtask

	task automatic t_brev;
		logic [15:0] v;
		logic [15:0] n;
		cba_mode_t   m;
		wr(3'h2, 16'h1000);
		wr(3'h3, 16'h1003);
		wr(3'h0, 16'h82f2);
		wr(3'h1, 16'h8008);
		rd(3'h1, 16'h8008);
		for (int i = 0; i < 16; i++) begin
			v = {11'h080, rev4(4'(i)), 1'b0};
			n = {11'h080, rev4(4'(i + 1)), 1'b0};
			m = i[0] ? CBA_PREMOD : CBA_POSTMOD;
			agu(0, 1, 0, m, 4'h2, v, 16'h0002);
			ex(i[0] ? n : v, 1, n, 0, 1);
		end
		wr(3'h1, 16'h8001);
		agu(0, 1, 0, CBA_POSTMOD, 4'h2, 16'h1000, 16'h0006);
		ex(16'h1000, 1, 16'h1002, 0, 1);
		agu(0, 0, 0, CBA_PREMOD, 4'h2, 16'h1002, 16'h0002);
		ex(16'h1000, 1, 16'h1000, 1, 0);
		agu(0, 0, 0, CBA_POSTMOD, 4'h2, 16'h1002, 16'h0002);
		ex(16'h1002, 1, 16'h1000, 1, 0);
		agu(0, 1, 1, CBA_POSTMOD, 4'h2, 16'h1000, 16'h0001);
		check({34'h0, r.reversed}, 35'h0);
		agu(0, 1, 0, CBA_REGOFF, 4'h2, 16'h1000, 16'h0002);
		check({34'h0, r.reversed}, 35'h0);
		agu(0, 1, 0, CBA_POSTMOD, 4'h2, 16'h1002, 16'hfffe);
		check({34'h0, r.reversed}, 35'h0);
		agu(1, 1, 0, CBA_POSTMOD, 4'h2, 16'h1000, 16'h0002);
		check({34'h0, r.reversed}, 35'h0);
		wr(3'h1, 16'h0008);
		agu(0, 1, 0, CBA_POSTMOD, 4'h2, 16'h1000, 16'h0002);
		check({34'h0, r.reversed}, 35'h0);
	endtask

	initial begin
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		t_regs();
		t_xcirc();
		t_ycirc();
		t_brev();
		stop_test();
	end

	// Fixed latencies leave no open wait; this only catches a stalled run
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		stop_test();
	end
endmodule
`default_nettype wire
